// ===== logic/lspd_pwm.v
`timescale 1ns/1ps
`default_nettype none
`include "lspd_consts.vh"

module lspd_pwm #(
	parameter REF_DIV = `LSPD_REF_DIV
) (
	input wire clk,
	input wire reset,
	input wire [6:0] duty,
	output reg pwm_out,
	output reg period_end
);

	reg [15:0] ref_cnt;
	reg ref_tick;
	reg [6:0] phase_cnt;
	reg [6:0] active_duty;

	// reference tick divider
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			ref_cnt <= 16'h0000;
			ref_tick <= 1'b0;
		end else if (ref_cnt == REF_DIV[15:0] - 16'h0001) begin
			ref_cnt <= 16'h0000;
			ref_tick <= 1'b1;
		end else begin
			ref_cnt <= ref_cnt + 16'h0001;
			ref_tick <= 1'b0;
		end
	end

	// R16: 128 ticks per period
	// R4: on for duty of 128 ticks
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			phase_cnt <= 7'h00;
			active_duty <= 7'h00;
			pwm_out <= 1'b0;
			period_end <= 1'b0;
		end else begin
			period_end <= 1'b0;
			if (ref_tick) begin
				phase_cnt <= phase_cnt + 7'h01;
				if (phase_cnt == 7'h7f) begin
					active_duty <= duty;
					period_end <= 1'b1;
					pwm_out <= (duty != 7'h00);
				end else begin
					pwm_out <= ((phase_cnt + 7'h01) < active_duty);
				end
			end
		end
	end

endmodule
`default_nettype wire

// ===== logic/lspd_top.v
// What this block does
// R1: peak code n gives duty 8n+7
// R2: middle code zero off, else 8n+7
// R3: floor code n gives duty 8n
// R4: duty D means D/128 on-time
// R5: pwm period is the hold time unit
// R6: scale zero: wait code times 0.50 s
// R7: scale one: wait code times 0.124 s
// R8: hold code zero holds one period
// R9: hold code n holds 75n periods
// R10: third hold code decoded the same way
// R11: fourth hold code decoded the same way
// R12: hold codes serve phases one to four
// R13: peak, middle, floor bound the slope
// R14: wait start delay after switch on
// R15: phase one ramps floor up to middle
// R16: period is 128 reference clock counts
`timescale 1ns/1ps
`default_nettype none
`include "lspd_consts.vh"

module lspd_top #(
	parameter REF_DIV = `LSPD_REF_DIV,
	parameter WAIT_UNIT0_PERIODS = `LSPD_WAIT_UNIT0_PERIODS,
	parameter WAIT_UNIT1_PERIODS = `LSPD_WAIT_UNIT1_PERIODS,
	parameter HOLD_PER_CODE = `LSPD_HOLD_PERIODS_PER_CODE
) (
	input wire clk,
	input wire reset,
	input wire channel_on,
	input wire [3:0] peak_duty_code,
	input wire [3:0] middle_duty_code,
	input wire [3:0] floor_duty_code,
	input wire [3:0] start_wait_code,
	input wire wait_scale_select,
	input wire [3:0] phase1_step_hold_code,
	input wire [3:0] phase2_step_hold_code,
	input wire [3:0] phase3_step_hold_code,
	input wire [3:0] phase4_step_hold_code,
	output wire led_pwm,
	output wire period_pulse,
	output reg [6:0] current_duty,
	output reg [6:0] peak_duty,
	output reg [6:0] middle_duty,
	output reg [6:0] floor_duty,
	output reg waiting,
	output reg [3:0] slope_phase
);

	localparam S_IDLE = 6'b000001;
	localparam S_WAIT = 6'b000010;
	localparam S_PH1 = 6'b000100;
	localparam S_PH2 = 6'b001000;
	localparam S_PH3 = 6'b010000;
	localparam S_PH4 = 6'b100000;

	// peak and nonzero middle encoding
	function [6:0] fill_duty;
		input [3:0] code;
		begin
			fill_duty = {code, `LSPD_DUTY_LOW_FILL};
		end
	endfunction

	// per-step hold in pwm periods
	function [11:0] hold_periods;
		input [3:0] code;
		reg [31:0] prod;
		begin
			prod = code * HOLD_PER_CODE;
			if (code == 4'h0) begin
				hold_periods = 12'h001;
			end else begin
				hold_periods = prod[11:0];
			end
		end
	endfunction

	reg [5:0] state;
	reg [5:0] next_state;
	reg [21:0] wait_cnt;
	reg [11:0] hold_cnt;
	reg [6:0] next_duty;
	reg [11:0] hold_target;
	reg [31:0] wait_prod;
	wire [21:0] wait_target;
	wire pwm_end;
	wire hold_done;

	lspd_pwm #(
		.REF_DIV(REF_DIV)
	) u_pwm (
		.clk(clk),
		.reset(reset),
		.duty(current_duty),
		.pwm_out(led_pwm),
		.period_end(pwm_end)
	);

	assign period_pulse = pwm_end;

	// decoded duties, registered
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			peak_duty <= `LSPD_DUTY_OFF;
			middle_duty <= `LSPD_DUTY_OFF;
			floor_duty <= `LSPD_DUTY_OFF;
		end else begin
			// R1: peak fill low bits
			peak_duty <= fill_duty(peak_duty_code);
			// R2: middle zero special case
			if (middle_duty_code == 4'h0) begin
				middle_duty <= `LSPD_DUTY_OFF;
			end else begin
				middle_duty <= fill_duty(middle_duty_code);
			end
			// R3: floor zero low bits
			floor_duty <= {floor_duty_code, `LSPD_DUTY_LOW_ZERO};
		end
	end

	// R6: R7: wait scale choice
	always @* begin
		if (wait_scale_select) begin
			wait_prod = start_wait_code * WAIT_UNIT1_PERIODS;
		end else begin
			wait_prod = start_wait_code * WAIT_UNIT0_PERIODS;
		end
	end
	assign wait_target = wait_prod[21:0];

	// R12: hold code per phase
	// R10: R11: same decode all phases
	always @* begin
		case (state)
			S_PH1: hold_target = hold_periods(phase1_step_hold_code);
			S_PH2: hold_target = hold_periods(phase2_step_hold_code);
			S_PH3: hold_target = hold_periods(phase3_step_hold_code);
			S_PH4: hold_target = hold_periods(phase4_step_hold_code);
			default: hold_target = 12'h001;
		endcase
	end

	// R8: R9: R5: step after hold periods
	assign hold_done = pwm_end && (hold_cnt + 12'h001 >= hold_target);

	// R13: slope between floor, middle, peak
	always @* begin
		next_state = state;
		next_duty = current_duty;
		case (state)
			S_IDLE: begin
				next_duty = `LSPD_DUTY_OFF;
				if (channel_on) begin
					next_state = S_WAIT;
				end
			end
			// R14: hold off until wait expires
			S_WAIT: begin
				next_duty = `LSPD_DUTY_OFF;
				if (wait_cnt >= wait_target) begin
					next_state = S_PH1;
					next_duty = floor_duty;
				end
			end
			// R15: ramp floor up to middle
			S_PH1: begin
				if (hold_done) begin
					if (current_duty >= middle_duty) begin
						next_state = S_PH2;
					end else begin
						next_duty = current_duty + 7'h01;
					end
				end
			end
			S_PH2: begin
				if (hold_done) begin
					if (current_duty >= peak_duty) begin
						next_state = S_PH3;
					end else begin
						next_duty = current_duty + 7'h01;
					end
				end
			end
			S_PH3: begin
				if (hold_done) begin
					if (current_duty <= middle_duty) begin
						next_state = S_PH4;
					end else begin
						next_duty = current_duty - 7'h01;
					end
				end
			end
			S_PH4: begin
				if (hold_done) begin
					if (current_duty <= floor_duty) begin
						next_state = S_PH1;
						next_duty = floor_duty;
					end else begin
						next_duty = current_duty - 7'h01;
					end
				end
			end
			default: begin
				next_state = S_IDLE;
				next_duty = `LSPD_DUTY_OFF;
			end
		endcase
		if (!channel_on) begin
			next_state = S_IDLE;
			next_duty = `LSPD_DUTY_OFF;
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= S_IDLE;
			current_duty <= `LSPD_DUTY_OFF;
			wait_cnt <= 22'h00_0000;
			hold_cnt <= 12'h000;
			waiting <= 1'b0;
			slope_phase <= 4'h0;
		end else begin
			state <= next_state;
			current_duty <= next_duty;
			// R14: count wait in pwm periods
			if (next_state != S_WAIT) begin
				wait_cnt <= 22'h00_0000;
			end else if (pwm_end && state == S_WAIT) begin
				wait_cnt <= wait_cnt + 22'h00_0001;
			end
			if (next_state != state || hold_done) begin
				hold_cnt <= 12'h000;
			end else if (pwm_end) begin
				hold_cnt <= hold_cnt + 12'h001;
			end
			waiting <= (next_state == S_WAIT);
			slope_phase <= next_state[5:2];
		end
	end

endmodule
`default_nettype wire

// ===== shared/lspd_consts.vh
`ifndef LSPD_CONSTS_VH
`define LSPD_CONSTS_VH

// clock and pwm timing
`define LSPD_CLK_PERIOD_NS 25
`define LSPD_PWM_PERIOD_NS 53300
`define LSPD_PWM_STEPS 128
// clk cycles per reference tick, rounded down, at least one
`define LSPD_REF_DIV ((`LSPD_PWM_PERIOD_NS / (`LSPD_CLK_PERIOD_NS * `LSPD_PWM_STEPS)) > 0 ? \
	(`LSPD_PWM_PERIOD_NS / (`LSPD_CLK_PERIOD_NS * `LSPD_PWM_STEPS)) : 1)

// start wait units
`define LSPD_WAIT_UNIT0_US 500000
`define LSPD_WAIT_UNIT1_US 124000
`define LSPD_WAIT_UNIT0_PERIODS ((`LSPD_WAIT_UNIT0_US * 1000) / `LSPD_PWM_PERIOD_NS)
`define LSPD_WAIT_UNIT1_PERIODS ((`LSPD_WAIT_UNIT1_US * 1000) / `LSPD_PWM_PERIOD_NS)

// step hold
`define LSPD_HOLD_PERIODS_PER_CODE 75

// duty code field layout
`define LSPD_DUTY_LOW_FILL 3'h7
`define LSPD_DUTY_LOW_ZERO 3'h0
`define LSPD_DUTY_OFF 7'h00

`endif

// ===== tb/lspd_led_sink.sv
`timescale 1ns/1ps
`default_nettype none
module lspd_led_sink (
	input wire clk,
	input wire led_pwm,
	input wire period_pulse,
	output reg [7:0] on_count
);
	reg [7:0] acc = 8'h00;
	always @(posedge clk) begin
		if (period_pulse) begin
			on_count <= acc + {7'h00, led_pwm};
			acc <= 8'h00;
		end else begin
			acc <= acc + {7'h00, led_pwm};
		end
	end
endmodule
`default_nettype wire

// ===== tb/lspd_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module lspd_props #(parameter REF_DIV = 1) (
	input wire clk,
	input wire reset,
	input wire channel_on,
	input wire [3:0] peak_duty_code,
	input wire [3:0] middle_duty_code,
	input wire [3:0] floor_duty_code,
	input wire period_pulse,
	input wire [6:0] current_duty,
	input wire [6:0] peak_duty,
	input wire [6:0] middle_duty,
	input wire [6:0] floor_duty,
	input wire waiting,
	input wire [3:0] slope_phase
);
	reg [15:0] gap;
	reg seen;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// clocks since last period end
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			gap <= 16'h0000;
			seen <= 1'b0;
		end else begin
			gap <= period_pulse ? 16'h0000 : gap + 16'h0001;
			seen <= seen | period_pulse;
		end
	end
	a_peak_decode:
		assert property (!$past(reset) |-> peak_duty == {$past(peak_duty_code), 3'h7})
		else $error("peak duty decode wrong");
	a_middle_decode:
		assert property (!$past(reset) |-> middle_duty == ($past(middle_duty_code) == 4'h0 ?
			7'h00 : {$past(middle_duty_code), 3'h7})) else $error("middle duty decode wrong");
	a_floor_decode:
		assert property (!$past(reset) |-> floor_duty == {$past(floor_duty_code), 3'h0})
		else $error("floor duty decode wrong");
	a_wait_entry:
		assert property ($rose(channel_on) && slope_phase == 4'h0 && !waiting |=> waiting)
		else $error("start wait not entered");
	a_phase_start:
		assert property ($rose(slope_phase[0]) && $past(waiting) |-> current_duty == floor_duty)
		else $error("phase one not from floor");
	a_rise_step:
		assert property (slope_phase[0] && $past(slope_phase[0]) && current_duty != $past(current_duty)
			|-> $past(period_pulse) && current_duty == $past(current_duty) + 7'h01)
		else $error("phase one step wrong");
	a_period_len:
		assert property (period_pulse && seen |-> gap == 128 * REF_DIV - 1)
		else $error("pwm period length wrong");
	a_off_idle:
		assert property ($fell(channel_on) |-> ##[1:2] (slope_phase == 4'h0 && !waiting))
		else $error("switch off not idle");
endmodule
bind lspd_top lspd_props #(.REF_DIV(REF_DIV)) u_props (.clk(clk), .reset(reset),
	.channel_on(channel_on), .peak_duty_code(peak_duty_code),
	.middle_duty_code(middle_duty_code), .floor_duty_code(floor_duty_code),
	.period_pulse(period_pulse), .current_duty(current_duty), .peak_duty(peak_duty),
	.middle_duty(middle_duty), .floor_duty(floor_duty), .waiting(waiting),
	.slope_phase(slope_phase));
`default_nettype wire

// ===== tb/lspd_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lspd_top_tb;
	reg clk = 1'b0;
	reg reset = 1'b1;
	reg channel_on = 1'b0;
	reg sel = 1'b0;
	reg [3:0] pk = 4'h0, md = 4'h0, fl = 4'h0, sw = 4'h0, h1 = 4'h0, h2 = 4'h0, h3 = 4'h0, h4 = 4'h0;
	reg [31:0] rng = 32'h0000_0016;
	reg [6:0] d;
	wire led_pwm, period_pulse, waiting;
	wire [6:0] cur, pkd, mdd, fld;
	wire [3:0] ph;
	wire [7:0] on_count;
	integer bad_count = 0, check_count = 0, i, n;
	always #12.5 clk = ~clk;
	lspd_top #(.REF_DIV(1), .WAIT_UNIT0_PERIODS(2), .WAIT_UNIT1_PERIODS(1), .HOLD_PER_CODE(2)) dut (
		.clk(clk), .reset(reset), .channel_on(channel_on), .peak_duty_code(pk),
		.middle_duty_code(md), .floor_duty_code(fl), .start_wait_code(sw), .wait_scale_select(sel),
		.phase1_step_hold_code(h1), .phase2_step_hold_code(h2), .phase3_step_hold_code(h3),
		.phase4_step_hold_code(h4), .led_pwm(led_pwm), .period_pulse(period_pulse),
		.current_duty(cur), .peak_duty(pkd), .middle_duty(mdd), .floor_duty(fld),
		.waiting(waiting), .slope_phase(ph));
	lspd_led_sink sink (.clk(clk), .led_pwm(led_pwm), .period_pulse(period_pulse),
		.on_count(on_count));
	function [31:0] xs(input [31:0] x);
		reg [31:0] y;
		begin
			y = x ^ (x << 13);
			y = y ^ (y >> 17);
			xs = y ^ (y << 5);
		end
	endfunction
	function [6:0] dec(input [3:0] c, input [1:0] k);
		dec = k == 2'h2 ? {c, 3'h0} : (k == 2'h1 && c == 4'h0) ? 7'h00 : {c, 3'h7};
	endfunction
	task check(input [31:0] seen, input [31:0] exp, input [47:0] what);
		begin
			check_count = check_count + 1;
			if (seen !== exp) begin
				bad_count = bad_count + 1;
				$display("BAD %0s expected %0h seen %0h", what, exp, seen);
			end
		end
	endtask
	task results;
		begin
			if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
			else $display("[ FAIL ]");
			$finish;
		end
	endtask
	task start(input [3:0] code, input s, input integer k);
		begin
			channel_on = 1'b0;
			sw = code;
			sel = s;
			repeat (3) @(negedge clk);
			channel_on = 1'b1;
			repeat (2) @(negedge clk);
			n = 0;
			while (waiting === 1'b1) begin
				@(negedge clk);
				n = n + 1;
			end
			check(n + 128 >= k * 128 && n <= k * 128 + 3, 1, "wait");
		end
	endtask
	task step_gap(input [3:0] phase, input integer per);
		begin
			while (ph !== phase) @(negedge clk);
			d = cur;
			while (cur === d) @(negedge clk);
			d = cur;
			n = 0;
			while (cur === d) begin
				@(negedge clk);
				n = n + 1;
			end
			check(n, per * 128, "hold");
		end
	endtask
	initial begin
		repeat (80000) @(posedge clk);
		bad_count = bad_count + 1;
		results;
	end
	initial begin
		repeat (16) @(negedge clk);
		reset = 1'b0;
		for (i = 0; i < 24; i = i + 1) begin
			rng = xs(rng);
			{pk, md, fl} = i < 16 ? {3{i[3:0]}} : rng[11:0];
			repeat (2) @(negedge clk);
			check(pkd, dec(pk, 2'h0), "peak");
			check(mdd, dec(md, 2'h1), "middle");
			check(fld, dec(fl, 2'h2), "floor");
		end
		{pk, md, fl, h1, h2, h3, h4} = 28'h532_0132;
		start(4'h0, 1'b0, 0);
		start(4'h1, 1'b0, 2);
		start(4'h2, 1'b1, 2);
		start(4'hf, 1'b1, 15);
		step_gap(4'h1, 1);
		step_gap(4'h2, 2);
		while (ph !== 4'h4) @(negedge clk);
		check(cur, dec(pk, 2'h0), "top");
		step_gap(4'h4, 6);
		check(cur, dec(pk, 2'h0) - 7'h02, "down");
		repeat (3) @(posedge period_pulse);
		repeat (2) @(negedge clk);
		check(on_count, dec(pk, 2'h0) - 7'h02, "ontime");
		step_gap(4'h8, 4);
		channel_on = 1'b0;
		repeat (3) @(negedge clk);
		check(ph, 0, "phase");
		results;
	end
endmodule
`default_nettype wire
